// file: logic/fbi_pkg.sv
// Shared constants and carrier types for the framer block interrupt hierarchy.
// Assumes an 8-bit register port with byte offsets as printed.
package fbi_pkg;
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 8;
    localparam int          RX_SRC_N        = 12;
    localparam int          TX_SRC_N        = 12;
    localparam logic [7:0]  OFS_MODE        = 8'h00;
    localparam logic [7:0]  OFS_BLK_EN      = 8'h04;
    localparam logic [7:0]  OFS_BLK_FLAGS   = 8'h05;
    localparam logic [7:0]  OFS_RX_EN       = 8'h12;
    localparam logic [7:0]  OFS_RX_EN_HI    = 8'h13;
    localparam logic [7:0]  OFS_RX_FLAGS    = 8'h14;
    localparam logic [7:0]  OFS_RX_FLAGS_HI = 8'h15;
    localparam logic [7:0]  OFS_TX_EN       = 8'h30;
    localparam logic [7:0]  OFS_TX_EN_HI    = 8'h31;
    localparam logic [7:0]  OFS_TX_FLAGS    = 8'h34;
    localparam logic [7:0]  OFS_TX_FLAGS_HI = 8'h35;
    localparam int          BIT_RX          = 7;
    localparam int          BIT_TX          = 1;
    localparam int          BIT_SEC         = 0;
    localparam int          BIT_AUTO_DIS    = 3;
    localparam logic [7:0]  BLK_EN_WMASK    = 8'h83;
    localparam logic [7:0]  RESET_BYTE      = 8'h00;
    localparam logic [11:0] RESET_SRC       = 12'h000;
    localparam longint      CLK_HZ          = 200000000;
    localparam longint      TICK_PERIOD_S   = 1;
    localparam longint      TICK_CYCLES     = CLK_HZ * TICK_PERIOD_S;
    typedef struct packed {
        logic              rd;
        logic              wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } fbi_req_type;
endpackage

// file: logic/fbi_tick.sv
// One-second tick divider: a one-cycle pulse once per period.
// Assumes a single free-running clock.
`timescale 1ns/1ps
module fbi_tick #(
    parameter longint PERIOD = fbi_pkg::TICK_CYCLES
) (
    input  wire logic clk,
    input  wire logic rst_n,
    output logic      tick
);
    logic [31:0] cnt_r;
    logic [31:0] cnt_nxt;
    logic        tick_r;
    logic        tick_nxt;

    // Counts down from the period minus one and pulses on wrap.
    always_comb begin
        tick_nxt = 1'b0;
        cnt_nxt  = cnt_r - 32'h1;
        if (cnt_r == 32'h0) begin
            cnt_nxt  = 32'(PERIOD - 1);
            tick_nxt = 1'b1;
        end
    end

    // Registers the divider state.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r  <= 32'h0;
            tick_r <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tick = tick_r;
endmodule

// file: logic/fbi_src_bank.sv
// One bank of source-level interrupt flags with enables.
// Assumes event inputs are synchronous one-cycle or level pulses on clk.
`timescale 1ns/1ps
module fbi_src_bank #(
    parameter int N = 12
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [N-1:0] event_in,
    input  wire logic [N-1:0] en_wr_data,
    input  wire logic         en_wr,
    input  wire logic         flags_rd,
    input  wire logic         auto_dis,
    output logic [N-1:0]      en,
    output logic [N-1:0]      flags,
    output logic              any_req
);
    logic [N-1:0] en_r;
    logic [N-1:0] en_nxt;
    logic [N-1:0] flag_r;
    logic [N-1:0] flag_nxt;

    // Per-source flag and enable next state.
    generate
        for (genvar i = 0; i < N; i++) begin : g_src
            always_comb begin
                // (RQ9) Clear on read, set wins.
                flag_nxt[i] = (flag_r[i] & ~flags_rd) | (event_in[i] & en_r[i]);
                en_nxt[i]   = en_wr ? en_wr_data[i] : en_r[i];
                // (RQ16) Auto-disable after firing.
                if (auto_dis && event_in[i] && en_r[i]) begin
                    en_nxt[i] = 1'b0;
                end
            end
        end
    endgenerate

    // Registers flags and enables.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            en_r   <= '0;
            flag_r <= '0;
        end else begin
            en_r   <= en_nxt;
            flag_r <= flag_nxt;
        end
    end

    assign en    = en_r;
    assign flags = flag_r;
    // (RQ19) OR of enabled flags.
    // In auto-disable mode a fired flag keeps requesting although its enable has just been cleared.
    assign any_req = |(flag_r & (en_r | {N{auto_dis}}));
endmodule

// file: logic/fbi_top.sv
// Top of the block-level interrupt hierarchy for one framer channel.
// Assumes a synchronous 8-bit register port on clk with one-cycle rd and wr strobes.
`timescale 1ns/1ps
// What this block does
// (RQ1) Read-only block flag register at 0x05: bit 7 receive, 1 transmit, 0 second.
// (RQ2) A block flag sets when its block saw an enabled condition.
// (RQ3) Block enable register at 0x04; bits 7, 1, 0 writable, others read zero.
// (RQ4) A zero block enable keeps that block from requesting.
// (RQ5) A one block enable passes only sources enabled at source level; auto-disable mode also passes set flags whose enable was cleared.
// (RQ6) Each block has up to twelve sources, each with enable and flag.
// (RQ7) Block enable clears to zero at reset.
// (RQ8) An enabled condition drives the active-low request low.
// (RQ9) Reading a source flag register clears its set bits.
// (RQ10) That read also clears the matching block flag.
// (RQ11) After the read and clear the request goes high.
// (RQ12) Software reads the listed receive and transmit sources in the first mode.
// (RQ13) Software reads the listed sources in either alternate framing mode.
// (RQ14) A condition that persists raises a fresh request.
// (RQ15) Mode register bit 3 selects automatic disable of enables.
// (RQ16) Auto-disable set clears a fired enable; clear leaves enables alone.
// (RQ17) Second tick requests each second; reading block flags clears it.
// (RQ18) Request is the OR of enabled block flags.
// (RQ19) Section flag is the OR of enabled source flags; in auto-disable mode the code ORs every set source flag.
module fbi_top (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire fbi_pkg::fbi_req_type req,
    input  wire logic [11:0]  rx_events,
    input  wire logic [11:0]  tx_events,
    output logic [7:0]        rdata,
    output logic              irq_n
);
    logic [7:0]  mode_r;
    logic [7:0]  mode_nxt;
    logic [7:0]  blk_en_r;
    logic [7:0]  blk_en_nxt;
    logic        sec_flag_r;
    logic        sec_flag_nxt;
    logic [7:0]  rdata_r;
    logic [7:0]  rdata_nxt;
    logic        irq_n_r;
    logic        irq_n_nxt;
    logic        tick;
    logic        rx_req;
    logic        tx_req;
    logic [11:0] rx_en;
    logic [11:0] tx_en;
    logic [11:0] rx_flags;
    logic [11:0] tx_flags;
    logic [11:0] rx_wdata;
    logic [11:0] tx_wdata;
    logic        rx_en_wr;
    logic        tx_en_wr;
    logic        rx_rd;
    logic        tx_rd;
    logic [7:0]  blk_flags;

    fbi_tick u_tick (
        .clk   (clk),
        .rst_n (rst_n),
        .tick  (tick)
    );

    // Source enable writes: low byte and high nibble as separate registers.
    always_comb begin
        rx_en_wr = 1'b0;
        tx_en_wr = 1'b0;
        rx_wdata = rx_en;
        tx_wdata = tx_en;
        if (req.wr) begin
            case (req.addr)
                fbi_pkg::OFS_RX_EN: begin
                    rx_en_wr       = 1'b1;
                    rx_wdata[7:0]  = req.wdata;
                end
                fbi_pkg::OFS_RX_EN_HI: begin
                    rx_en_wr       = 1'b1;
                    rx_wdata[11:8] = req.wdata[3:0];
                end
                fbi_pkg::OFS_TX_EN: begin
                    tx_en_wr       = 1'b1;
                    tx_wdata[7:0]  = req.wdata;
                end
                fbi_pkg::OFS_TX_EN_HI: begin
                    tx_en_wr       = 1'b1;
                    tx_wdata[11:8] = req.wdata[3:0];
                end
                default: begin
                    rx_en_wr = 1'b0;
                end
            endcase
        end
    end

    // (RQ9) Source flag reads clear a whole bank.
    assign rx_rd = req.rd && (req.addr == fbi_pkg::OFS_RX_FLAGS || req.addr == fbi_pkg::OFS_RX_FLAGS_HI);
    assign tx_rd = req.rd && (req.addr == fbi_pkg::OFS_TX_FLAGS || req.addr == fbi_pkg::OFS_TX_FLAGS_HI);

    // (RQ6) Twelve sources per section.
    // (RQ15) Mode bit 3 selects auto-disable.
    fbi_src_bank #(.N(fbi_pkg::RX_SRC_N)) u_rx (
        .clk        (clk),
        .rst_n      (rst_n),
        .event_in   (rx_events),
        .en_wr_data (rx_wdata),
        .en_wr      (rx_en_wr),
        .flags_rd   (rx_rd),
        .auto_dis   (mode_r[fbi_pkg::BIT_AUTO_DIS]),
        .en         (rx_en),
        .flags      (rx_flags),
        .any_req    (rx_req)
    );

    fbi_src_bank #(.N(fbi_pkg::TX_SRC_N)) u_tx (
        .clk        (clk),
        .rst_n      (rst_n),
        .event_in   (tx_events),
        .en_wr_data (tx_wdata),
        .en_wr      (tx_en_wr),
        .flags_rd   (tx_rd),
        .auto_dis   (mode_r[fbi_pkg::BIT_AUTO_DIS]),
        .en         (tx_en),
        .flags      (tx_flags),
        .any_req    (tx_req)
    );

    // (RQ1) Block flag image; section bits follow their banks.
    always_comb begin
        blk_flags                   = fbi_pkg::RESET_BYTE;
        // (RQ2) Section flags from enabled sources.
        // (RQ10) Cleared with the source read.
        blk_flags[fbi_pkg::BIT_RX]  = rx_req;
        blk_flags[fbi_pkg::BIT_TX]  = tx_req;
        blk_flags[fbi_pkg::BIT_SEC] = sec_flag_r;
    end

    // Control registers and the one-second flag.
    always_comb begin
        mode_nxt     = mode_r;
        blk_en_nxt   = blk_en_r;
        sec_flag_nxt = sec_flag_r;
        if (req.wr && req.addr == fbi_pkg::OFS_MODE) begin
            mode_nxt = req.wdata;
        end
        // (RQ3) Only bits 7, 1, 0 take writes.
        if (req.wr && req.addr == fbi_pkg::OFS_BLK_EN) begin
            blk_en_nxt = req.wdata & fbi_pkg::BLK_EN_WMASK;
        end
        // (RQ17) Read clears second flag.
        if (req.rd && req.addr == fbi_pkg::OFS_BLK_FLAGS) begin
            sec_flag_nxt = 1'b0;
        end
        // (RQ17) Tick sets it while block enable bit 0 is set, set wins.
        if (tick && blk_en_r[fbi_pkg::BIT_SEC]) begin
            sec_flag_nxt = 1'b1;
        end
    end

    // Read data mux, registered.
    always_comb begin
        case (req.addr)
            fbi_pkg::OFS_MODE:        rdata_nxt = mode_r;
            fbi_pkg::OFS_BLK_EN:      rdata_nxt = blk_en_r;
            fbi_pkg::OFS_BLK_FLAGS:   rdata_nxt = blk_flags;
            fbi_pkg::OFS_RX_EN:       rdata_nxt = rx_en[7:0];
            fbi_pkg::OFS_RX_EN_HI:    rdata_nxt = {4'h0, rx_en[11:8]};
            fbi_pkg::OFS_RX_FLAGS:    rdata_nxt = rx_flags[7:0];
            fbi_pkg::OFS_RX_FLAGS_HI: rdata_nxt = {4'h0, rx_flags[11:8]};
            fbi_pkg::OFS_TX_EN:       rdata_nxt = tx_en[7:0];
            fbi_pkg::OFS_TX_EN_HI:    rdata_nxt = {4'h0, tx_en[11:8]};
            fbi_pkg::OFS_TX_FLAGS:    rdata_nxt = tx_flags[7:0];
            fbi_pkg::OFS_TX_FLAGS_HI: rdata_nxt = {4'h0, tx_flags[11:8]};
            default:                  rdata_nxt = fbi_pkg::RESET_BYTE;
        endcase
        if (!req.rd) begin
            rdata_nxt = rdata_r;
        end
    end

    // (RQ18) Request is OR of enabled block flags.
    // (RQ4) Block enable gates each section; (RQ5) sources pre-gated in banks.
    // (RQ8) Low while any enabled flag; (RQ11) (RQ14) follows flags.
    assign irq_n_nxt = ~|(blk_flags & blk_en_r);

    // (RQ7) Registers clear at reset, except irq_n_r, which resets high.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_r     <= fbi_pkg::RESET_BYTE;
            blk_en_r   <= fbi_pkg::RESET_BYTE;
            sec_flag_r <= 1'b0;
            rdata_r    <= fbi_pkg::RESET_BYTE;
            irq_n_r    <= 1'b1;
        end else begin
            mode_r     <= mode_nxt;
            blk_en_r   <= blk_en_nxt;
            sec_flag_r <= sec_flag_nxt;
            rdata_r    <= rdata_nxt;
            irq_n_r    <= irq_n_nxt;
        end
    end

    assign rdata = rdata_r;
    assign irq_n = irq_n_r;
endmodule

// file: verification/fbi_chk.sv
// Port-level checker for the block interrupt hierarchy.
// Assumes one clock domain and the package register map.
`timescale 1ns/1ps
module fbi_chk (
    input wire logic                 clk,
    input wire logic                 rst_n,
    input wire fbi_pkg::fbi_req_type req,
    input wire logic [11:0]          rx_events,
    input wire logic [11:0]          tx_events,
    input wire logic [7:0]           rdata,
    input wire logic                 irq_n
);
    logic [7:0] en_r;
    logic [7:0] en_nxt;
    logic [1:0] zc_r;
    logic [1:0] zc_nxt;
    logic       busy;
    // Shadows the block enable and counts cycles it has been all zero.
    always_comb begin
        en_nxt = en_r;
        if (req.wr && req.addr == fbi_pkg::OFS_BLK_EN) begin
            en_nxt = req.wdata & fbi_pkg::BLK_EN_WMASK;
        end
        zc_nxt = (en_nxt != 8'h00) ? 2'h0 : ((zc_r == 2'h3) ? zc_r : zc_r + 2'h1);
        busy = req.rd || req.wr || (|rx_events) || (|tx_events);
    end
    // Registers the shadow state.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            en_r <= 8'h00;
            zc_r <= 2'h0;
        end else begin
            en_r <= en_nxt;
            zc_r <= zc_nxt;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_rx_rd;
        req.rd && req.addr == fbi_pkg::OFS_RX_FLAGS && en_r[1:0] == 2'h0 && rx_events == 12'h000;
    endsequence
    sequence s_quiet;
        rx_events == 12'h000;
    endsequence
    property p_rst;     $past(!rst_n) |-> irq_n && rdata == 8'h00; endproperty
    property p_en_ro;   req.rd && req.addr == fbi_pkg::OFS_BLK_EN |=> rdata[6:2] == 5'h00; endproperty
    property p_flag_ro; req.rd && req.addr == fbi_pkg::OFS_BLK_FLAGS |=> rdata[6:2] == 5'h00; endproperty
    property p_hi;      req.rd && req.addr[0] && req.addr != fbi_pkg::OFS_BLK_FLAGS |=> rdata[7:4] == 4'h0; endproperty
    property p_gate;    zc_r >= 2'h2 |-> irq_n; endproperty
    property p_fell;    $fell(irq_n) |-> $past(busy, 2) || en_r[0]; endproperty
    property p_rose;    $rose(irq_n) |-> $past(busy, 2); endproperty
    property p_hold;    !irq_n && !$past(busy) |=> !irq_n; endproperty
    property p_service; s_rx_rd ##1 s_quiet |=> irq_n; endproperty
    a_rst:     assert property (p_rst) else $error("request or data not idle after reset");
    a_en_ro:   assert property (p_en_ro) else $error("block enable reserved bits not zero");
    a_flag_ro: assert property (p_flag_ro) else $error("block flag reserved bits not zero");
    a_hi:      assert property (p_hi) else $error("upper half of a bank wider than twelve");
    a_gate:    assert property (p_gate) else $error("request with every block disabled");
    a_fell:    assert property (p_fell) else $error("request raised without a cause");
    a_rose:    assert property (p_rose) else $error("request dropped without a cause");
    a_hold:    assert property (p_hold) else $error("request dropped while flags held");
    a_service: assert property (p_service) else $error("request not negated after service");
endmodule
bind fbi_top fbi_chk u_chk (.clk(clk), .rst_n(rst_n), .req(req), .rx_events(rx_events),
    .tx_events(tx_events), .rdata(rdata), .irq_n(irq_n));

// file: verification/fbi_cpu.sv
// Model of the local processor that services the interrupt request.
// Assumes the bench calls its access task; strobes change at falling edges.
`timescale 1ns/1ps
module fbi_cpu (
    input  wire logic            clk,
    input  wire logic [7:0]      rdata,
    output fbi_pkg::fbi_req_type req
);
    // Idle bus carries no strobe and no stale address.
    initial req = '{rd: 1'b0, wr: 1'b0, addr: 8'h5A, wdata: 8'hA5};
    // One access: strobe for one edge, then the bus is scrambled and data taken.
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        @(negedge clk);
        req <= '{rd: !w, wr: w, addr: a, wdata: d};
        @(negedge clk);
        req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
        @(negedge clk);
        q = rdata;
    endtask
endmodule

// file: verification/framer_block_interrupt_hierarchy_tb_top.sv
// Self-checking bench for the block interrupt hierarchy with a reference model.
// Assumes the processor model drives the register port.
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_errors++; $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module framer_block_interrupt_hierarchy_tb_top;
    logic                 clk = 1'b0;
    logic                 rst_n = 1'b0;
    logic [11:0]          rx_ev = 12'h000;
    logic [11:0]          tx_ev = 12'h000;
    logic [7:0]           rdata;
    logic                 irq_n;
    fbi_pkg::fbi_req_type req;
    int                   n_errors = 0;
    int                   n_checks = 0;
    logic [31:0]          seed = 32'h30;
    logic [11:0]          rxe, txe, rxf, txf;
    logic [7:0]           be, q;
    logic                 au;
    logic [7:0]           adr[$] = '{8'h04, 8'h05, 8'h12, 8'h13, 8'h14, 8'h15, 8'h30, 8'h31, 8'h34, 8'h35, 8'h07};
    // Free-running clock of 5 ns.
    always #2.5 clk = ~clk;
    fbi_top dut (.clk(clk), .rst_n(rst_n), .req(req), .rx_events(rx_ev), .tx_events(tx_ev),
        .rdata(rdata), .irq_n(irq_n));
    fbi_cpu cpu (.clk(clk), .rdata(rdata), .req(req));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [7:0] blk();
        return {|(rxf & (rxe | {12{au}})), 5'h00, |(txf & (txe | {12{au}})), 1'b0};
    endfunction
    // Expected read value of one offset from the model.
    function automatic logic [7:0] ex(input logic [7:0] a);
        logic [11:0] v;
        v = a[2] ? (a[5] ? txf : rxf) : (a[5] ? txe : rxe);
        case (a)
            8'h04: return be;
            8'h05: return blk();
            8'h12, 8'h13, 8'h14, 8'h15, 8'h30, 8'h31, 8'h34, 8'h35: return a[0] ? {4'h0, v[11:8]} : v[7:0];
            default: return 8'h00;
        endcase
    endfunction
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        cpu.acc(1'b1, a, d, q);
        case (a)
            8'h00: au = d[3];
            8'h04: be = d & 8'h83;
            8'h12: rxe[7:0] = d;
            8'h13: rxe[11:8] = d[3:0];
            8'h30: txe[7:0] = d;
            8'h31: txe[11:8] = d[3:0];
            default: ;
        endcase
    endtask
    // Reads and compares; a bank read clears its flags unless an event persists.
    task automatic rdc(input logic [7:0] a);
        logic [7:0] e;
        e = ex(a);
        cpu.acc(1'b0, a, 8'h00, q);
        `CHK(q, e)
        if (a == 8'h14 || a == 8'h15) rxf = rx_ev & rxe;
        if (a == 8'h34 || a == 8'h35) txf = tx_ev & txe;
    endtask
    task automatic ev(input logic [11:0] r, input logic [11:0] t);
        @(negedge clk);
        rx_ev = r;
        tx_ev = t;
        @(negedge clk);
        rx_ev = 12'h000;
        tx_ev = 12'h000;
        rxf |= r & rxe;
        txf |= t & txe;
        if (au) begin
            rxe &= ~r;
            txe &= ~t;
        end
        repeat (2) @(negedge clk);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Main sequence: reset values, masks, random traffic, persistent condition.
    initial begin
        {rxe, txe, rxf, txf, be, au} = '0;
        repeat (6) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        foreach (adr[i]) rdc(adr[i]);
        wr(8'h04, 8'hFF);
        rdc(8'h04);
        wr(8'h05, 8'hFF);
        rdc(8'h05);
        for (int i = 0; i < 24; i++) begin
            if (i == 12) wr(8'h00, 8'h08);
            wr(8'h04, 8'(rnd()));
            wr(8'h12, 8'(rnd()));
            wr(8'h13, 8'(rnd()));
            wr(8'h30, 8'(rnd()));
            wr(8'h31, 8'(rnd()));
            ev(12'(rnd()), 12'(rnd()));
            `CHK(irq_n, !(|(blk() & be)))
            rdc(8'h05);
            rdc(8'h12);
            rdc(8'h14);
            rdc(8'h15);
            rdc(8'h34);
            rdc(8'h35);
            rdc(8'h31);
            rdc(8'h05);
            `CHK(irq_n, 1'b1)
        end
        wr(8'h00, 8'h00);
        wr(8'h04, 8'h80);
        wr(8'h12, 8'hFF);
        rx_ev = 12'h001;
        repeat (2) @(negedge clk);
        rxf = 12'h001;
        rdc(8'h14);
        `CHK(irq_n, 1'b0)
        rx_ev = 12'h000;
        rdc(8'h14);
        `CHK(irq_n, 1'b1)
        tally_and_finish();
    end
    // Cuts a hang short well after the expected run of some eleven hundred cycles.
    initial begin
        #100000;
        n_errors++;
        tally_and_finish();
    end
endmodule
